// File: common/rsp_pkg.sv
// package: constants and the checksum function shared by the rate sensor serial ends
package rsp_pkg;
  localparam int          MSG_BYTES    = 6;
  localparam int          MSG_BITS     = 48;
  localparam int          CMD_MODE_BIT = 7;
  localparam int          CMD_TEST_BIT = 6;
  localparam int          CMD_SRC_BIT  = 5;
  localparam int          ST_FAIL_BIT  = 7;
  localparam int          ST_BAD_BIT   = 4;
  localparam int          ST_TEST_BIT  = 3;
  localparam logic [1:0]  ST_TYPE_RATE = 2'h0;
  localparam logic [2:0]  ST_NORMAL    = 3'h1;
  localparam logic [1:0]  CMD_RANGE    = 2'h1;
  localparam logic [15:0] TEMP_ZERO    = 16'h0200;
  // host timing, figures in ns
  localparam int          CLK_NS       = 5;
  localparam int          T_START_NS   = 25000;
  localparam int          T_STOP_NS    = 5000;
  localparam int          T_HOLD_NS    = 15000;
  localparam int          T_START_CYC  = (T_START_NS + CLK_NS - 1) / CLK_NS;
  localparam int          T_STOP_CYC   = (T_STOP_NS + CLK_NS - 1) / CLK_NS;
  localparam int          T_HOLD_CYC   = (T_HOLD_NS + CLK_NS - 1) / CLK_NS;
  // shortest spacing of message starts, so polling never exceeds 10 kHz
  localparam int          T_POLL_NS    = 100000;
  localparam int          T_POLL_CYC   = (T_POLL_NS + CLK_NS - 1) / CLK_NS;
  localparam int          CTRL_GO_BIT  = 8;
  localparam int          CTRL_BAD_BIT = 9;
  localparam int          SCK_HALF_CYC = 100;
  localparam logic [7:0]  HOST_CMD_DEF = 8'h30;
  // register port of the host
  localparam logic [3:0]  HREG_CTRL    = 4'h0;
  localparam logic [3:0]  HREG_STAT    = 4'h4;
  localparam logic [3:0]  HREG_RATE    = 4'h8;
  localparam logic [3:0]  HREG_TEMP    = 4'hc;

  function automatic logic [7:0] rsp_sum(input logic [39:0] b);
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < 5; i++) begin
      s = s + b[8*i +: 8];
    end
    return ~s;
  endfunction
endpackage

// File: common/rsp_if.sv
// interface: the four wire serial link between host and sensor
`timescale 1ns/10ps
interface rsp_if;
  logic sck;
  logic sel_n;
  logic mosi;
  logic miso;
  logic miso_oe;
  wire  miso_bus = miso_oe ? miso : 1'b1;
  modport dev  (input sck, input sel_n, input mosi, output miso, output miso_oe);
  modport host (output sck, output sel_n, output mosi, input miso_bus);
endinterface

// File: logic/rsp_dev.sv
// design: sensor end of the serial message port
`timescale 1ns/10ps
module rsp_dev
  import rsp_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        mode_sel_i,
  input  wire logic        health_fail_i,
  input  wire logic [15:0] rate_i,
  input  wire logic [15:0] temp_i,
  output logic             self_test_o,
  output logic             range_ext_o,
  output logic [1:0]       range_sel_o,
  rsp_if.dev               link
);
  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] sck_s, sel_s, mosi_s, mode_s;
  logic       sck_d;
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      sck_s  <= 2'h0;
      sel_s  <= 2'h3;
      mosi_s <= 2'h0;
      mode_s <= 2'h0;
      sck_d  <= 1'b0;
    end else if (ce_i) begin
      sck_s  <= {sck_s[0], link.sck};
      sel_s  <= {sel_s[0], link.sel_n};
      mosi_s <= {mosi_s[0], link.mosi};
      mode_s <= {mode_s[0], mode_sel_i};
      sck_d  <= sck_s[1];
    end
  end
  wire active  = mode_s[1] & ~sel_s[1];
  wire rise    = active & sck_s[1] & ~sck_d;
  wire fall    = active & ~sck_s[1] & sck_d;
  // ---------------------------------------------------------------
  // message shifters
  // ---------------------------------------------------------------
  logic [47:0] rx, tx;
  logic [5:0]  nbits;
  logic        bad, in_msg;
  logic [7:0]  status;
  logic [39:0] reply;
  assign status = {health_fail_i | self_test_o, ST_TYPE_RATE, bad, self_test_o,
                   ST_NORMAL};
  assign reply  = {status, rate_i, temp_i};
  wire   done   = in_msg & ~active & (nbits == 6'(MSG_BITS));
  wire   good   = rsp_sum(rx[47:8]) == rx[7:0];
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rx <= '0; tx <= '0; nbits <= '0; in_msg <= 1'b0;
    end else if (ce_i) begin
      in_msg <= active;
      if (active & ~in_msg) begin
        tx    <= {reply, rsp_sum(reply)};
        nbits <= '0;
      end else if (rise) begin
        rx    <= {rx[46:0], mosi_s[1]};
        nbits <= nbits + 6'h1;
      end else if (fall) begin
        tx    <= {tx[46:0], 1'b0};
      end
    end
  end
  // ---------------------------------------------------------------
  // command state
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      bad <= 1'b0; self_test_o <= 1'b0; range_ext_o <= 1'b0; range_sel_o <= CMD_RANGE;
    end else if (ce_i && done) begin
      bad <= ~good;
      if (good) begin
        self_test_o <= rx[40+CMD_TEST_BIT];
        range_ext_o <= rx[40+CMD_SRC_BIT];
        range_sel_o <= rx[44:43];
      end
    end
  end
  assign link.miso    = tx[47];
  assign link.miso_oe = active;
endmodule // rsp_dev

// File: logic/rsp_host.sv
// design: host end, a serial master polled through registers
//
// Decided for this implementation: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
module rsp_host
  import rsp_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic [3:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic [31:0]      rdata_o,
  rsp_if.host              link
);
  typedef enum logic [1:0] {H_IDLE = 2'b00, H_START = 2'b01, H_SHIFT = 2'b11,
                            H_STOP = 2'b10} rsp_st_t;
  rsp_st_t     st;
  logic [15:0] cnt;
  logic [5:0]  nbits;
  logic [47:0] tx, rx, last;
  logic [7:0]  cmd;
  logic        busy_q, sck, sel_n, miso_a, miso_b, rx_ok;
  logic [15:0] hold, pace;
  logic        bad_sum;
  wire        go           = wr_i & (addr_i == HREG_CTRL) & wdata_i[CTRL_GO_BIT];
  // the command goes out with the write that starts it, not with the one before
  wire [7:0]  next_cmd     = {1'b0, wdata_i[CMD_TEST_BIT], wdata_i[CMD_SRC_BIT], CMD_RANGE,
                              3'h0};
  wire        next_bad_sum = wdata_i[CTRL_BAD_BIT];
  wire [39:0] cbody        = {next_cmd, 32'h0000_0000};
  // diagnostic: an inverted checksum lets the sensor's rejection be exercised
  wire [7:0]  csum         = rsp_sum(cbody) ^ {8{next_bad_sum}};
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      st <= H_IDLE; cnt <= '0; nbits <= '0; tx <= '0; rx <= '0; last <= '0;
      cmd <= HOST_CMD_DEF; sck <= 1'b0; sel_n <= 1'b1; miso_a <= 1'b1;
      miso_b <= 1'b1; rx_ok <= 1'b0; hold <= '0; pace <= '0; bad_sum <= 1'b0;
    end else if (ce_i) begin
      miso_a <= link.miso_bus;
      miso_b <= miso_a;
      if (hold != 16'h0) hold <= hold - 16'h1;
      if (pace != 16'h0) pace <= pace - 16'h1;
      if (wr_i && addr_i == HREG_CTRL) begin
        cmd     <= next_cmd;
        bad_sum <= next_bad_sum;
      end
      unique case (st)
        H_IDLE: if (go && hold == 16'h0 && pace == 16'h0) begin
          st <= H_START; sel_n <= 1'b0; cnt <= 16'(T_START_CYC);
          tx <= {cbody, csum}; nbits <= '0; pace <= 16'(T_POLL_CYC);
        end
        H_START: if (cnt == 16'h0) begin
          st <= H_SHIFT; cnt <= 16'(SCK_HALF_CYC);
        end else cnt <= cnt - 16'h1;
        H_SHIFT: if (cnt == 16'h0) begin
          cnt <= 16'(SCK_HALF_CYC);
          sck <= ~sck;
          if (!sck) begin
            rx <= {rx[46:0], miso_b}; nbits <= nbits + 6'h1;
          end else begin
            tx <= {tx[46:0], 1'b0};
            if (nbits == 6'(MSG_BITS)) begin
              st <= H_STOP; cnt <= 16'(T_STOP_CYC);
            end
          end
        end else cnt <= cnt - 16'h1;
        H_STOP: if (cnt == 16'h0) begin
          st <= H_IDLE; sel_n <= 1'b1; last <= rx; hold <= 16'(T_HOLD_CYC);
          rx_ok <= rsp_sum(rx[47:8]) == rx[7:0];
        end else cnt <= cnt - 16'h1;
      endcase
    end
  end
  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  assign busy_q = (st != H_IDLE) | (hold != 16'h0) | (pace != 16'h0);
  wire [31:0] rsel = (addr_i == HREG_CTRL) ? {22'h0, bad_sum, 1'b0, cmd} :
                     (addr_i == HREG_STAT) ? {22'h0, rx_ok, busy_q, last[47:40]} :
                     (addr_i == HREG_RATE) ? {16'h0, last[39:24]} :
                     (addr_i == HREG_TEMP) ? {16'h0, last[23:8]} : 32'h0000_0000;
  always_ff @(posedge clock_i) begin
    if (rst_i) rdata_o <= '0;
    else if (ce_i && rd_i) rdata_o <= rsel;
  end
  assign link.sck   = sck;
  assign link.sel_n = sel_n;
  assign link.mosi  = tx[47];
endmodule // rsp_host

// File: verification/rsp_checker.sv
// checker: link timing and framing checks between host and sensor ends
`timescale 1ns/10ps
module rsp_checker
  import rsp_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic sck,
  input wire logic sel_n,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe,
  input wire logic mode_sel
);
  logic        ps;
  logic        pn;
  logic [15:0] gap;
  logic [15:0] since;
  logic [6:0]  nb;
  // gap counts quiet cycles since the last edge on clock or select, saturating
  always_ff @(posedge clock_i) begin
    ps  <= sck;
    pn  <= sel_n;
    gap <= (rst_i || sck != ps || sel_n != pn) ? 16'h0000 : gap + 16'(gap != 16'hffff);
    nb  <= sel_n ? 7'h00 : nb + 7'(sck & ~ps);
    // cycles since the last select fall, saturating; full after reset
    since <= rst_i ? 16'hffff :
             (!sel_n && pn) ? 16'h0000 : since + 16'(since != 16'hffff);
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  AST_IDLE_LOW: assert property (sel_n |-> !sck) else $error("clock not low at idle");
  AST_MOSI_HELD: assert property ($rose(sck) |-> $stable(mosi)) else $error("mosi moved");
  AST_MISO_HELD: assert property (sck && ps |-> $stable(miso)) else $error("miso moved");
  AST_OE_ON: assert property ($fell(sel_n) && mode_sel |-> ##[1:3] miso_oe) else $error("no drive");
  AST_MODE_OFF: assert property ((!mode_sel) [*4] |-> !miso_oe) else $error("drive in analogue mode");
  AST_PACE: assert property ($fell(sel_n) |-> since >= 16'(T_POLL_CYC - 2))
    else $error("poll rate too high");
  AST_OE_OFF: assert property (sel_n [*4] |-> !miso_oe) else $error("not released");
  AST_START: assert property ($rose(sck) && nb == 7'h00 |-> gap >= 16'(T_START_CYC - 2))
    else $error("start gap short");
  AST_STOP: assert property ($rose(sel_n) |-> gap >= 16'(T_STOP_CYC - 2))
    else $error("stop gap short");
  AST_HOLD: assert property ($fell(sel_n) |-> gap >= 16'(T_HOLD_CYC - 2))
    else $error("hold gap short");
  AST_FRAME: assert property ($rose(sel_n) |-> nb == 7'h30) else $error("not 48 bits");
endmodule // rsp_checker

// File: verification/test_rate_sensor_spi_message_port.sv
// testbench: messages run through the host register port into the sensor end
`timescale 1ns/10ps
module test_rate_sensor_spi_message_port;
  import rsp_pkg::*;
  logic        clock_i, rst_i, wr, rd, fail, st, rx, mode;
  logic [1:0]  rs;
  logic [3:0]  addr;
  logic [15:0] rate, temp;
  logic [31:0] wdata, rdata, v;
  int          error_cnt, tests_run;
  rsp_if link ();
  rsp_host rsp_host_inst (.clock_i(clock_i), .rst_i(rst_i), .ce_i(1'b1), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .link(link));
  rsp_dev rsp_dev_inst (.clock_i(clock_i), .rst_i(rst_i), .ce_i(1'b1), .mode_sel_i(mode),
    .health_fail_i(fail), .rate_i(rate), .temp_i(temp), .self_test_o(st),
    .range_ext_o(rx), .range_sel_o(rs), .link(link));
  rsp_checker rsp_checker_inst (.clock_i(clock_i), .rst_i(rst_i), .sck(link.sck),
    .sel_n(link.sel_n), .mosi(link.mosi), .miso(link.miso), .miso_oe(link.miso_oe),
    .mode_sel(mode));
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic acc(logic w, logic [3:0] a, logic [31:0] d);
    @(posedge clock_i);
    addr  <= a;
    wdata <= d;
    wr    <= w;
    rd    <= !w;
    @(posedge clock_i);
    wr    <= 1'b0;
    rd    <= 1'b0;
    #1 v = rdata;
  endtask
  // the reply is captured at select fall, so it shows the state before this command
  // ed is the expected sensor state after the message: self-test, range source
  task automatic msg(logic [31:0] c, logic [7:0] es, logic [1:0] ed);
    acc(1'b1, HREG_CTRL, c | 32'h0000_0100);
    v = 32'h0000_0100;
    for (int i = 0; i < 30000 && v[8] !== 1'b0; i++) acc(1'b0, HREG_STAT, 32'h0000_0000);
    chk("status", {22'h0, v[9:0]}, {24'h00_0002, es});
    acc(1'b0, HREG_RATE, 32'h0000_0000);
    chk("rate", {16'h0, v[15:0]}, {16'h0, rate});
    acc(1'b0, HREG_TEMP, 32'h0000_0000);
    chk("temp", {16'h0, v[15:0]}, {16'h0, temp});
    chk("dev", {28'h0, st, rx, rs}, {28'h0, ed, CMD_RANGE});
  endtask
  task automatic results();
    $display("errors %0d checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end
  initial begin
    #450_000;
    error_cnt++;
    results();
  end
  initial begin
    {rst_i, wr, rd, fail, mode, addr, wdata} = {5'b10001, 4'h0, 32'h0000_0000};
    rate = 16'hf4c0;
    temp = 16'h0192;
    error_cnt = 0;
    tests_run = 0;
    repeat (6) @(posedge clock_i);
    rst_i <= 1'b0;
    @(posedge clock_i);
    #1 chk("reset", {29'h0, st, rs}, {29'h0, 1'b0, CMD_RANGE});
    repeat (3100) @(posedge clock_i);
    msg(32'h0000_0020, 8'h01, 2'b01);
    fail <= 1'b1;
    rate <= 16'h12c0;
    temp <= 16'h02e9;
    msg(32'h0000_0040, 8'h81, 2'b10);
    fail <= 1'b0;
    // bit 9 corrupts the checksum: the sensor keeps its state, flags the next reply
    msg(32'h0000_0200, 8'h89, 2'b10);
    msg(32'h0000_0000, 8'h99, 2'b00);
    mode <= 1'b0;
    acc(1'b1, HREG_CTRL, 32'h0000_0100);
    repeat (8) @(posedge clock_i);
    #1 chk("released", {30'h0, link.sel_n, link.miso_oe}, 32'h0000_0000);
    results();
  end
endmodule // test_rate_sensor_spi_message_port
